// [src/masa_alu.sv]
// Eight-bit arithmetic and shift datapath with an APB register slave
`timescale 1ns/1ps
// Operation
// - add immediate into working register, four flags
// - add memory byte, result to either place
// - add memory plus link bit, either place
// - add link bit alone, store in place
// - subtract immediate or memory from working register
// - memory minus working register into memory
// - working register minus memory minus link
// - memory minus working register minus link
// - subtract link bit alone, store in place
// - increment memory byte, four flags
// - decrement memory byte, four flags
// - clear memory byte, flags untouched
// - shift right zero fill, old b0 to link
// - shift right through link bit
// - shift left zero fill, old b7 to link
// - shift left through link bit
// - swap nibbles of working register, flags untouched
module masa_alu
	import masa_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire masa_req_t dec_req,
	output masa_mem_t mem_out,
	output logic done,
	output logic [7:0] working_register,
	output logic [3:0] flags
);

	////////////////////////////////////////////////////////////////
	// Arithmetic helper

	// Result record: {link, half, wrap, value}
	typedef struct packed {
		logic link;
		logic half;
		logic wrap;
		logic [7:0] value;
	} masa_sum_t;

	// Adds or subtracts with carry in; borrow reported as link set
	function automatic masa_sum_t masa_addsub(
		input logic [7:0] a,
		input logic [7:0] b,
		input logic cin,
		input logic sub
	);
		logic [7:0] bb;
		logic ci;
		logic [4:0] lo;
		logic [8:0] full;
		masa_sum_t r;
		bb = sub ? ~b : b;
		ci = sub ? ~cin : cin;
		// Two's complement addition serves both directions
		lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
		full = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
		// Carry inverted gives borrow on subtract
		r.link = full[8] ^ sub;
		r.half = lo[4] ^ sub;
		r.wrap = (a[7] == bb[7]) && (full[7] != a[7]);
		r.value = full[7:0];
		return r;
	endfunction : masa_addsub

	////////////////////////////////////////////////////////////////
	// Bus decode

	logic [7:0] acc_q; // Working register
	logic [3:0] flags_q; // Z, C, AC, OV
	logic [7:0] memres_q; // Last byte sent to memory
	logic [31:0] prdata_q; // Read data
	logic pready_q; // Zero wait access
	logic pslverr_q; // Unmapped offset
	logic mem_we_q; // Memory write strobe
	logic [7:0] mem_wdata_q; // Memory write data
	logic done_q; // Instruction retired

	logic setup; // Setup phase of a transfer
	logic acc_wr; // Access phase write, completing
	logic [7:0] ofs; // Offset in low byte
	logic hit; // Offset is mapped
	assign setup = psel && !penable;
	assign acc_wr = psel && penable && pwrite && pready_q;
	assign ofs = paddr[7:0];
	assign hit = (ofs == MASA_OFS_WORK) || (ofs == MASA_OFS_FLAGS) ||
		(ofs == MASA_OFS_CMD) || (ofs == MASA_OFS_MEMRES);

	////////////////////////////////////////////////////////////////
	// Instruction source

	masa_op_t op; // Selected operation
	logic [7:0] opnd; // Immediate or memory byte
	logic go; // Execute this cycle
	logic cmd_wr; // Command register write
	assign cmd_wr = acc_wr && (ofs == MASA_OFS_CMD);

	// Decoder has priority; a colliding bus command is dropped
	always_comb begin
		if (dec_req.valid) begin
			op = dec_req.op;
			opnd = dec_req.operand;
			go = 1'b1;
		end else begin
			op = masa_op_t'(pwdata[MASA_CMD_OP_LSB +: 5]);
			opnd = pwdata[MASA_CMD_OPR_LSB +: 8];
			go = cmd_wr;
		end
	end

	////////////////////////////////////////////////////////////////
	// Datapath

	masa_sum_t s; // Arithmetic result
	logic [7:0] res; // Value written back
	logic to_acc; // Result goes to working register
	logic to_mem; // Result goes to memory
	logic arith; // All four flags take the sum
	logic shift; // Only link takes the shifted-out bit
	logic sh_link; // Bit shifted out
	logic link; // Current link bit
	assign link = flags_q[MASA_F_LINK];

	// Operation decode and result selection
	always_comb begin
		s = masa_addsub(acc_q, opnd, 1'b0, 1'b0);
		res = s.value;
		to_acc = 1'b0;
		to_mem = 1'b0;
		arith = 1'b0;
		shift = 1'b0;
		sh_link = 1'b0;
		case (op)
			MASA_OP_ADD_AI, MASA_OP_ADD_AM: begin
				s = masa_addsub(acc_q, opnd, 1'b0, 1'b0);
				to_acc = 1'b1;
				arith = 1'b1;
			end
			MASA_OP_ADD_MA: begin
				s = masa_addsub(opnd, acc_q, 1'b0, 1'b0);
				to_mem = 1'b1;
				arith = 1'b1;
			end
			MASA_OP_ADDC_AM: begin
				s = masa_addsub(acc_q, opnd, link, 1'b0);
				to_acc = 1'b1;
				arith = 1'b1;
			end
			MASA_OP_ADDC_MA: begin
				s = masa_addsub(opnd, acc_q, link, 1'b0);
				to_mem = 1'b1;
				arith = 1'b1;
			end
			MASA_OP_ADDC_A: begin
				s = masa_addsub(acc_q, MASA_ZERO, link, 1'b0);
				to_acc = 1'b1;
				arith = 1'b1;
			end
			MASA_OP_ADDC_M: begin
				s = masa_addsub(opnd, MASA_ZERO, link, 1'b0);
				to_mem = 1'b1;
				arith = 1'b1;
			end
			MASA_OP_SUB_AI, MASA_OP_SUB_AM: begin
				s = masa_addsub(acc_q, opnd, 1'b0, 1'b1);
				to_acc = 1'b1;
				arith = 1'b1;
			end
			MASA_OP_SUB_MA: begin
				s = masa_addsub(opnd, acc_q, 1'b0, 1'b1);
				to_mem = 1'b1;
				arith = 1'b1;
			end
			MASA_OP_SUBC_AM: begin
				s = masa_addsub(acc_q, opnd, link, 1'b1);
				to_acc = 1'b1;
				arith = 1'b1;
			end
			MASA_OP_SUBC_MA: begin
				s = masa_addsub(opnd, acc_q, link, 1'b1);
				to_mem = 1'b1;
				arith = 1'b1;
			end
			MASA_OP_SUBC_A: begin
				s = masa_addsub(acc_q, MASA_ZERO, link, 1'b1);
				to_acc = 1'b1;
				arith = 1'b1;
			end
			MASA_OP_SUBC_M: begin
				s = masa_addsub(opnd, MASA_ZERO, link, 1'b1);
				to_mem = 1'b1;
				arith = 1'b1;
			end
			MASA_OP_INC_M: begin
				s = masa_addsub(opnd, MASA_ONE, 1'b0, 1'b0);
				to_mem = 1'b1;
				arith = 1'b1;
			end
			MASA_OP_DEC_M: begin
				s = masa_addsub(opnd, MASA_ONE, 1'b0, 1'b1);
				to_mem = 1'b1;
				arith = 1'b1;
			end
			MASA_OP_CLR_M: begin
				to_mem = 1'b1;
			end
			MASA_OP_SRZ_A, MASA_OP_SRZ_M, MASA_OP_SRC_A, MASA_OP_SRC_M,
			MASA_OP_SLZ_A, MASA_OP_SLZ_M, MASA_OP_SLC_A, MASA_OP_SLC_M: begin
				// Shifts act in place: the source is also the destination
				to_acc = op inside {MASA_OP_SRZ_A, MASA_OP_SRC_A, MASA_OP_SLZ_A, MASA_OP_SLC_A};
				to_mem = !to_acc;
				shift = 1'b1;
			end
			MASA_OP_SWAP_A: begin
				to_acc = 1'b1;
			end
			default: begin
				// No operation: nothing written
			end
		endcase
		// Value selection, source is the destination for shifts
		res = s.value;
		case (op)
			MASA_OP_CLR_M: res = MASA_ZERO;
			MASA_OP_SRZ_A, MASA_OP_SRZ_M, MASA_OP_SRC_A, MASA_OP_SRC_M: begin
				res = to_acc ? acc_q : opnd;
				sh_link = res[0];
				res = {(op == MASA_OP_SRC_A || op == MASA_OP_SRC_M) && link, res[7:1]};
			end
			MASA_OP_SLZ_A, MASA_OP_SLZ_M, MASA_OP_SLC_A, MASA_OP_SLC_M: begin
				res = to_acc ? acc_q : opnd;
				sh_link = res[7];
				res = {res[6:0], (op == MASA_OP_SLC_A || op == MASA_OP_SLC_M) && link};
			end
			MASA_OP_SWAP_A: res = {acc_q[3:0], acc_q[7:4]};
			default: res = s.value; // Keep the sum
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Working register

	// Execution beats a same-cycle bus write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= MASA_WORK_RST;
		end else if (go && to_acc) begin
			acc_q <= res;
		end else if (acc_wr && ofs == MASA_OFS_WORK) begin
			acc_q <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Flags

	// Arithmetic sets all four, shifts only link, others none
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= MASA_FLAGS_RST;
		end else if (go && arith) begin
			flags_q[MASA_F_NULL] <= (s.value == MASA_ZERO);
			flags_q[MASA_F_LINK] <= s.link;
			flags_q[MASA_F_HALF] <= s.half;
			flags_q[MASA_F_WRAP] <= s.wrap;
		end else if (go && shift) begin
			flags_q[MASA_F_LINK] <= sh_link;
		end else if (acc_wr && ofs == MASA_OFS_FLAGS) begin
			flags_q <= pwdata[3:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Memory write-back

	// One-cycle strobe the edge after the request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_we_q <= 1'b0;
			mem_wdata_q <= MASA_ZERO;
			memres_q <= MASA_ZERO;
			done_q <= 1'b0;
		end else begin
			mem_we_q <= go && to_mem;
			done_q <= go;
			if (go && to_mem) begin
				mem_wdata_q <= res;
				memres_q <= res;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Bus answer

	// Data captured in setup so pready and prdata both come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !hit;
			if (setup) begin
				case (ofs)
					MASA_OFS_WORK: prdata_q <= {24'h00_0000, acc_q};
					MASA_OFS_FLAGS: prdata_q <= {28'h000_0000, flags_q};
					MASA_OFS_MEMRES: prdata_q <= {24'h00_0000, memres_q};
					default: prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign mem_out = '{we: mem_we_q, data: mem_wdata_q};
	assign done = done_q;
	assign working_register = acc_q;
	assign flags = flags_q;

endmodule : masa_alu

// [src/masa_pkg.sv]
// Shared constants and types of the eight-bit arithmetic and shift datapath
package masa_pkg;

	// Datapath width
	localparam int MASA_DW = 8;

	// Register byte offsets on the bus
	localparam logic [7:0] MASA_OFS_WORK = 8'h00;
	localparam logic [7:0] MASA_OFS_FLAGS = 8'h04;
	localparam logic [7:0] MASA_OFS_CMD = 8'h08;
	localparam logic [7:0] MASA_OFS_MEMRES = 8'h0c;

	// Flag bit positions in the flags register
	localparam int MASA_F_NULL = 0;
	localparam int MASA_F_LINK = 1;
	localparam int MASA_F_HALF = 2;
	localparam int MASA_F_WRAP = 3;

	// Command register fields
	localparam int MASA_CMD_OP_LSB = 0;
	localparam int MASA_CMD_OPR_LSB = 8;

	// Reset values
	localparam logic [7:0] MASA_WORK_RST = 8'h00;
	localparam logic [3:0] MASA_FLAGS_RST = 4'h0;

	// Fixed operands
	localparam logic [7:0] MASA_ONE = 8'h01;
	localparam logic [7:0] MASA_ZERO = 8'h00;

	// Instruction codes seen from the decoder or the command register
	typedef enum logic [4:0] {
		MASA_OP_NOP = 5'h00,
		MASA_OP_ADD_AI = 5'h01,
		MASA_OP_ADD_AM = 5'h02,
		MASA_OP_ADD_MA = 5'h03,
		MASA_OP_ADDC_AM = 5'h04,
		MASA_OP_ADDC_MA = 5'h05,
		MASA_OP_ADDC_A = 5'h06,
		MASA_OP_ADDC_M = 5'h07,
		MASA_OP_SUB_AI = 5'h08,
		MASA_OP_SUB_AM = 5'h09,
		MASA_OP_SUB_MA = 5'h0a,
		MASA_OP_SUBC_AM = 5'h0b,
		MASA_OP_SUBC_MA = 5'h0c,
		MASA_OP_SUBC_A = 5'h0d,
		MASA_OP_SUBC_M = 5'h0e,
		MASA_OP_INC_M = 5'h0f,
		MASA_OP_DEC_M = 5'h10,
		MASA_OP_CLR_M = 5'h11,
		MASA_OP_SRZ_A = 5'h12,
		MASA_OP_SRZ_M = 5'h13,
		MASA_OP_SRC_A = 5'h14,
		MASA_OP_SRC_M = 5'h15,
		MASA_OP_SLZ_A = 5'h16,
		MASA_OP_SLZ_M = 5'h17,
		MASA_OP_SLC_A = 5'h18,
		MASA_OP_SLC_M = 5'h19,
		MASA_OP_SWAP_A = 5'h1a
	} masa_op_t;

	// Request from the instruction decoder
	typedef struct packed {
		logic valid;
		masa_op_t op;
		logic [7:0] operand;
	} masa_req_t;

	// Write-back toward data memory
	typedef struct packed {
		logic we;
		logic [7:0] data;
	} masa_mem_t;

endpackage : masa_pkg

// [testbench/masa_alu_chk.sv]
// Port checker of the arithmetic and shift datapath
`timescale 1ns/1ps
module masa_alu_chk
	import masa_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire masa_req_t dec_req,
	input wire masa_mem_t mem_out,
	input wire logic [7:0] working_register,
	input wire logic [3:0] flags
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////
	logic [7:0] w_q; // Register before the op
	logic [7:0] v_q; // Operand of the op
	logic [3:0] f_q; // Flags before the op
	masa_op_t op; // Op taken, NOP when idle
	assign op = dec_req.valid ? dec_req.op : MASA_OP_NOP;
	// One cycle of history ties each result to its source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{w_q, v_q, f_q} <= '0;
		end else begin
			{w_q, v_q, f_q} <= {working_register, dec_req.operand, flags};
		end
	end
	////////////////////////////////////////////////////////////
	chk_add_imm: assert property (op == MASA_OP_ADD_AI |=> working_register == w_q + v_q)
		else $error("add immediate result wrong");
	chk_inc_mem: assert property (op == MASA_OP_INC_M |=> mem_out.we && mem_out.data == v_q + 8'h01)
		else $error("increment result wrong");
	chk_clr_keep: assert property (op == MASA_OP_CLR_M |=> mem_out.we && mem_out.data == 8'h00 && flags == f_q)
		else $error("clear wrong");
	chk_srz_work: assert property (op == MASA_OP_SRZ_A |=> working_register == {1'b0, w_q[7:1]} && flags[1] == w_q[0])
		else $error("right shift wrong");
	chk_src_work: assert property (op == MASA_OP_SRC_A |=> working_register == {f_q[1], w_q[7:1]} && flags[1] == w_q[0])
		else $error("right rotate wrong");
	chk_slz_work: assert property (op == MASA_OP_SLZ_A |=> working_register == {w_q[6:0], 1'b0} && flags[1] == w_q[7])
		else $error("left shift wrong");
	chk_slc_work: assert property (op == MASA_OP_SLC_A |=> working_register == {w_q[6:0], f_q[1]} && flags[1] == w_q[7])
		else $error("left rotate wrong");
	chk_swap_keep: assert property (op == MASA_OP_SWAP_A |=> working_register == {w_q[3:0], w_q[7:4]} && flags == f_q)
		else $error("swap wrong");
	chk_zero_add: assert property (op == MASA_OP_ADD_AI |=> flags[MASA_F_NULL] == (working_register == 8'h00))
		else $error("zero flag wrong");
	chk_dec_mem: assert property (op == MASA_OP_DEC_M |=> mem_out.we && mem_out.data == v_q - 8'h01 &&
		flags[MASA_F_LINK] == (v_q == 8'h00))
		else $error("decrement result wrong");
endmodule : masa_alu_chk

bind masa_alu masa_alu_chk i_chk (.pclk(pclk), .presetn(presetn), .dec_req(dec_req), .mem_out(mem_out),
	.working_register(working_register), .flags(flags));

// [testbench/masa_mem_model.sv]
// Data memory byte behind the write-back port
`timescale 1ns/1ps
module masa_mem_model
	import masa_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire masa_mem_t mem_out,
	output logic [7:0] rd_data
);
	// Keep each write-back; readable from the next cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data <= 8'h00;
		end else if (mem_out.we) begin
			rd_data <= mem_out.data;
		end
	end
endmodule : masa_mem_model

// [testbench/masa_alu_tb.sv]
// Self-checking bench of the arithmetic and shift datapath
`timescale 1ns/1ps
module masa_alu_tb
	import masa_pkg::*;
;
	typedef struct packed {logic we; logic [7:0] d; logic [7:0] w; logic [3:0] f;} masa_exp_t;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic pready, pslverr, done, sev;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	masa_req_t dec_req = '0;
	masa_mem_t mem_out;
	logic [7:0] working_register, mdat, w_s, m_last;
	logic [3:0] flags, f_s;
	int err_count = 0;
	int num_checks = 0;
	masa_exp_t exp_q[$], mon_e; // Expected results in issue order
	masa_op_t chain[6] = '{MASA_OP_CLR_M, MASA_OP_DEC_M, MASA_OP_INC_M, MASA_OP_SUBC_MA, MASA_OP_ADDC_M, MASA_OP_SLC_M};

	masa_alu i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dec_req(dec_req), .mem_out(mem_out), .done(done), .working_register(working_register), .flags(flags));
	masa_mem_model i_mem (.pclk(pclk), .presetn(presetn), .mem_out(mem_out), .rd_data(mdat));

	initial begin
		forever #2.5 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////
	// Reference result: write-back, register and flags
	function automatic masa_exp_t ref_f(masa_op_t o, logic [7:0] w, logic [7:0] m, logic [3:0] f);
		masa_exp_t e;
		logic [7:0] a, b, x, r;
		logic c, s, mw, ar;
		logic [8:0] t;
		logic [4:0] h;
		e = '{1'b0, 8'h00, w, f};
		{a, b, mw, ar} = {w, m, 2'b01};
		c = f[1] && (o inside {[MASA_OP_ADDC_AM:MASA_OP_ADDC_M], [MASA_OP_SUBC_AM:MASA_OP_SUBC_M]});
		s = o inside {[MASA_OP_SUB_AI:MASA_OP_SUBC_M], MASA_OP_DEC_M};
		case (o)
			MASA_OP_ADD_AI, MASA_OP_ADD_AM, MASA_OP_ADDC_AM, MASA_OP_SUB_AI, MASA_OP_SUB_AM, MASA_OP_SUBC_AM: ;
			MASA_OP_ADD_MA, MASA_OP_ADDC_MA, MASA_OP_SUB_MA, MASA_OP_SUBC_MA: {a, b, mw} = {m, w, 1'b1};
			MASA_OP_ADDC_A, MASA_OP_SUBC_A: b = 8'h00;
			MASA_OP_ADDC_M, MASA_OP_SUBC_M: {a, b, mw} = {m, 8'h00, 1'b1};
			MASA_OP_INC_M, MASA_OP_DEC_M: {a, b, mw} = {m, 8'h01, 1'b1};
			default: ar = 1'b0;
		endcase
		if (ar) begin
			t = s ? {1'b0, a} - b - c : {1'b0, a} + b + c;
			h = s ? {1'b0, a[3:0]} - b[3:0] - c : {1'b0, a[3:0]} + b[3:0] + c;
			r = t[7:0];
			e.f = {(a[7] ^ r[7]) & (a[7] ^ b[7] ^ !s), h[4], t[8], r == 8'h00};
		end else begin
			mw = o inside {MASA_OP_SRZ_M, MASA_OP_SRC_M, MASA_OP_SLZ_M, MASA_OP_SLC_M, MASA_OP_CLR_M};
			x = mw ? m : w;
			case (o)
				MASA_OP_SRZ_A, MASA_OP_SRZ_M: {r, e.f[1]} = {1'b0, x};
				MASA_OP_SRC_A, MASA_OP_SRC_M: {r, e.f[1]} = {f[1], x};
				MASA_OP_SLZ_A, MASA_OP_SLZ_M: {e.f[1], r} = {x, 1'b0};
				MASA_OP_SLC_A, MASA_OP_SLC_M: {e.f[1], r} = {x, f[1]};
				MASA_OP_SWAP_A: r = {x[3:0], x[7:4]};
				MASA_OP_CLR_M: r = 8'h00;
				default: r = w;
			endcase
		end
		if (mw) {e.we, e.d} = {1'b1, r};
		else e.w = r;
		return e;
	endfunction : ref_f

	task automatic cmp_val(string n, logic [7:0] e, logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : cmp_val

	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report

	// Note the result, then issue the op when drv is set
	task automatic op(masa_op_t o, logic [7:0] v, bit drv);
		masa_exp_t e;
		e = ref_f(o, w_s, v, f_s);
		{w_s, f_s} = {e.w, e.f};
		if (e.we) m_last = e.d;
		exp_q.push_back(e);
		if (drv) begin
			dec_req <= {1'b1, o, v};
			@(posedge pclk);
		end
	endtask : op

	task automatic idle();
		dec_req.valid <= 1'b0;
		@(posedge pclk);
	endtask : idle

	// One transfer; an extra edge after release keeps drives apart
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			final_report();
		end
		{rdv, sev} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
		@(posedge pclk);
	endtask : apb
	////////////////////////////////////////////////////////////
	// Each done takes the oldest note off the queue
	always @(posedge pclk) begin
		if (presetn === 1'b1 && done === 1'b1) begin
			cmp_val("note_ready", 8'h01, {7'h0, exp_q.size() != 0});
			if (exp_q.size() != 0) mon_e = exp_q.pop_front();
			cmp_val("work", mon_e.w, working_register);
			cmp_val("flags", {4'h0, mon_e.f}, {4'h0, flags});
			cmp_val("mem_we", {7'h0, mon_e.we}, {7'h0, mem_out.we});
			if (mon_e.we) cmp_val("mem_data", mon_e.d, mem_out.data);
		end
	end

	initial begin
		void'($urandom(49706));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, MASA_OFS_WORK, 32'h0);
		cmp_val("work_rst", 8'h00, rdv[7:0]);
		cmp_val("okay_resp", 8'h00, {7'h0, sev});
		apb(1'b1, MASA_OFS_WORK, 32'h3c);
		apb(1'b1, MASA_OFS_FLAGS, 32'h2);
		apb(1'b0, MASA_OFS_FLAGS, 32'h0);
		cmp_val("flags_rd", 8'h02, rdv[7:0]);
		{w_s, f_s, m_last} = 20'h3c200;
		apb(1'b0, 8'h10, 32'h0);
		cmp_val("unmapped_err", 8'h01, {7'h0, sev});
		// Every code once back to back, then a random stream
		for (int i = 0; i < 432; i++) begin
			op(masa_op_t'(5'(i < 32 ? i : $urandom_range(0, 26))), 8'($urandom), 1'b1);
		end
		// Write-back lands in memory and feeds the next op
		foreach (chain[k]) begin
			op(chain[k], mdat, 1'b1);
			idle();
			idle();
			cmp_val("mem_byte", m_last, mdat);
		end
		op(MASA_OP_ADD_AI, 8'h81, 1'b0);
		apb(1'b1, MASA_OFS_CMD, {16'h0, 8'h81, 3'h0, MASA_OP_ADD_AI});
		apb(1'b0, MASA_OFS_MEMRES, 32'h0);
		cmp_val("memres", m_last, rdv[7:0]);
		apb(1'b0, MASA_OFS_WORK, 32'h0);
		cmp_val("work_rd", w_s, rdv[7:0]);
		repeat (3) @(posedge pclk);
		cmp_val("pending", 8'h00, 8'(exp_q.size()));
		final_report();
	end
endmodule : masa_alu_tb
